// [logic/sac_adc_ctrl.sv]
// Successive approximation converter control with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module sac_adc_ctrl (
    input wire logic CORE_CLK, // 50 MHz clock
    input wire logic SYS_RST, // Synchronous active high reset
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] TRIG_IN, // Trigger sources 1..7, bit 0 unused
    input wire logic CMP_OUT, // Analog comparator decision
    output logic [9:0] DAC_CODE, // Trial code to comparator DAC
    output logic [3:0] ANA_MUX_SEL, // Applied channel, 8=gnd 9=bandgap
    output logic [1:0] ANA_REF_SEL, // Applied reference
    output logic ANA_ENABLE, // Analog power up
    output logic SAMPLE_HOLD // High while sampling
);
    logic [7:0] in_sel_reg; // Buffered input select
    logic [7:0] ctrl_a_reg; // Control a bits
    logic [2:0] trig_sel_reg; // Trigger source select
    logic power_gate_reg; // Power reduction bit
    logic [7:0] res_low_reg, res_high_reg; // Result bytes
    logic lock_reg; // Result update block
    logic first_reg; // Next conversion is the first
    logic [6:0] presc_reg; // Prescaler count
    logic [4:0] cyc_reg; // Converter clocks into conversion
    logic [9:0] sar_reg; // Approximation register
    logic [3:0] bit_reg; // Bit under trial
    logic [1:0] sync_reg; // Trigger sync delay
    logic trig_d_reg; // Delayed trigger level
    logic [7:0] mux_act_reg; // Selection used by converter
    sac_pkg::sac_state_e state_reg;
    logic wr, rd, en, adc_tick, trig_lvl, trig_edge, sw_start, done, cur_left;
    logic [4:0] conv_len;
    logic [9:0] res;
    sac_pkg::sac_mux_s mux_view;

    // Bus strobes, zero wait state
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    // Enable is usable only with the power gate open
    assign en = ctrl_a_reg[`SAC_EN_BIT] && !power_gate_reg; // see RULE6

    // Prescaler tick at selected division 2..128
    always_comb begin
        adc_tick = 1'b0;
        case (ctrl_a_reg[`SAC_PS_LSB +: 3])
            3'h0, 3'h1: adc_tick = presc_reg[0];
            3'h2: adc_tick = &presc_reg[1:0];
            3'h3: adc_tick = &presc_reg[2:0];
            3'h4: adc_tick = &presc_reg[3:0];
            3'h5: adc_tick = &presc_reg[4:0];
            3'h6: adc_tick = &presc_reg[5:0];
            default: adc_tick = &presc_reg;
        endcase
    end

    // Trigger source level, done flag or external line
    assign trig_lvl = (trig_sel_reg == `SAC_TS_DONE) ? ctrl_a_reg[`SAC_DONE_BIT] : TRIG_IN[trig_sel_reg];
    assign trig_edge = trig_lvl && !trig_d_reg && ctrl_a_reg[`SAC_AUTO_BIT] && en; // see RULE15
    assign sw_start = wr && PADDR == `SAC_OFS_CTRL_A && PWDATA[`SAC_START_BIT];
    assign conv_len = first_reg ? `SAC_FIRST_CYC : `SAC_NORMAL_CYC; // see RULE21
    assign done = state_reg == sac_pkg::ST_CONV && adc_tick && cyc_reg == conv_len - 5'd1;
    // Final code with the last trial bit settled
    assign res = (bit_reg == 4'd0) ? (CMP_OUT ? sar_reg : sar_reg & 10'h3fe) : sar_reg;
    assign cur_left = in_sel_reg[`SAC_LEFT_BIT];

    // Previous trigger level for edge detect
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            trig_d_reg <= 1'b0;
        end else begin
            trig_d_reg <= trig_lvl;
        end
    end

    // Prescaler runs while enabled, reset by trigger
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || !en) begin
            presc_reg <= 7'h00; // see RULE22
        end else if (trig_edge && state_reg == sac_pkg::ST_IDLE) begin
            presc_reg <= 7'h00; // see RULE16
        end else begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // Conversion sequencer
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || !en) begin
            state_reg <= sac_pkg::ST_IDLE;
            cyc_reg <= 5'd0;
            sync_reg <= 2'd0;
            sar_reg <= 10'h000;
            bit_reg <= 4'd9;
        end else begin
            case (state_reg)
                sac_pkg::ST_IDLE: begin
                    if (trig_edge) begin
                        state_reg <= sac_pkg::ST_SYNC; // see RULE16
                        sync_reg <= 2'd0;
                    end else if (sw_start || ctrl_a_reg[`SAC_START_BIT]) begin
                        state_reg <= sac_pkg::ST_CONV; // see RULE13
                        cyc_reg <= 5'd0;
                        sar_reg <= 10'h200;
                        bit_reg <= 4'd9;
                    end
                end
                sac_pkg::ST_SYNC: begin
                    // Fixed synchronisation delay
                    if (sync_reg == `SAC_SYNC_CYC - 2'd1) begin
                        state_reg <= sac_pkg::ST_CONV; // see RULE24
                        cyc_reg <= 5'd0;
                        sar_reg <= 10'h200;
                        bit_reg <= 4'd9;
                    end else begin
                        sync_reg <= sync_reg + 2'd1;
                    end
                end
                sac_pkg::ST_CONV: begin
                    if (adc_tick) begin
                        cyc_reg <= cyc_reg + 5'd1;
                        // Resolve one bit per clock in the ten clocks before the last
                        if (cyc_reg >= conv_len - 5'd11 && cyc_reg < conv_len - 5'd1) begin
                            if (!CMP_OUT) begin
                                sar_reg[bit_reg] <= 1'b0; // see RULE25
                            end
                            if (bit_reg != 4'd0) begin
                                sar_reg[bit_reg - 4'd1] <= 1'b1;
                                bit_reg <= bit_reg - 4'd1;
                            end
                        end
                        if (done) begin
                            // Free running restarts at once, others go idle
                            if (ctrl_a_reg[`SAC_AUTO_BIT] && trig_sel_reg == `SAC_TS_DONE) begin
                                cyc_reg <= 5'd0; // see RULE19
                                sar_reg <= 10'h200;
                                bit_reg <= 4'd9;
                            end else begin
                                state_reg <= sac_pkg::ST_IDLE; // see RULE17
                            end
                        end
                    end
                end
                default: state_reg <= sac_pkg::ST_IDLE;
            endcase
        end
    end

    // First conversion marker after enabling
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || !en) begin
            first_reg <= 1'b1;
        end else if (done) begin
            first_reg <= 1'b0;
        end
    end

    // Control a register with start and done flag
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ctrl_a_reg <= 8'h00; // see RULE26
        end else begin
            if (wr && PADDR == `SAC_OFS_CTRL_A) begin
                ctrl_a_reg[`SAC_EN_BIT] <= PWDATA[`SAC_EN_BIT];
                ctrl_a_reg[`SAC_AUTO_BIT] <= PWDATA[`SAC_AUTO_BIT];
                ctrl_a_reg[`SAC_PS_LSB +: 4] <= PWDATA[`SAC_PS_LSB +: 4];
                if (PWDATA[`SAC_START_BIT] && en) begin
                    ctrl_a_reg[`SAC_START_BIT] <= 1'b1; // see RULE20
                end
                if (PWDATA[`SAC_DONE_BIT]) begin
                    ctrl_a_reg[`SAC_DONE_BIT] <= 1'b0; // see RULE18
                end
            end
            if (trig_edge && state_reg == sac_pkg::ST_IDLE) begin
                ctrl_a_reg[`SAC_START_BIT] <= 1'b1; // see RULE20
            end
            if (done) begin
                ctrl_a_reg[`SAC_DONE_BIT] <= 1'b1; // see RULE12
                if (!(ctrl_a_reg[`SAC_AUTO_BIT] && trig_sel_reg == `SAC_TS_DONE)) begin
                    ctrl_a_reg[`SAC_START_BIT] <= 1'b0; // see RULE23
                end
            end
            if (!en) begin
                ctrl_a_reg[`SAC_START_BIT] <= 1'b0;
            end
        end
    end

    // Other writable registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            in_sel_reg <= 8'h00;
            trig_sel_reg <= 3'h0;
            power_gate_reg <= 1'b0;
        end else if (wr) begin
            case (PADDR)
                `SAC_OFS_INPUT_SEL: in_sel_reg <= PWDATA[7:0];
                `SAC_OFS_CTRL_B: trig_sel_reg <= PWDATA[`SAC_TS_LSB +: 3];
                `SAC_OFS_POWER: power_gate_reg <= PWDATA[0];
                default: in_sel_reg <= in_sel_reg;
            endcase
        end
    end

    // Applied selection follows buffer only when idle and enabled
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mux_act_reg <= 8'h00;
        end else if (en && state_reg == sac_pkg::ST_IDLE) begin
            mux_act_reg <= in_sel_reg; // see RULE5 RULE14
        end
    end

    // Decode applied selection, codes 0..7 pins, 0x1e bandgap, 0x1f ground
    always_comb begin
        mux_view.channel = mux_act_reg[2:0]; // see RULE4
        mux_view.use_bg = mux_act_reg[4:0] == 5'h1e; // see RULE3
        mux_view.use_gnd = mux_act_reg[4:0] == 5'h1f;
        mux_view.ref_sel = mux_act_reg[`SAC_REF_LSB +: 2]; // see RULE2
    end
    assign ANA_MUX_SEL = mux_view.use_gnd ? 4'h8 : (mux_view.use_bg ? 4'h9 : {1'b0, mux_view.channel});
    assign ANA_REF_SEL = mux_view.ref_sel;
    assign ANA_ENABLE = en;
    assign SAMPLE_HOLD = state_reg == sac_pkg::ST_CONV && cyc_reg < conv_len - 5'd11;
    assign DAC_CODE = sar_reg; // see RULE1

    // Result bytes, locked between low and high reads
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            res_low_reg <= 8'h00;
            res_high_reg <= 8'h00;
        end else if (done && !lock_reg) begin
            if (cur_left) begin
                res_high_reg <= res[9:2]; // see RULE7
                res_low_reg <= {res[1:0], 6'h00};
            end else begin
                res_high_reg <= {6'h00, res[9:8]};
                res_low_reg <= res[7:0];
            end
        end // see RULE9
    end

    // Lock set by low byte read, cleared by high byte read
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            lock_reg <= 1'b0;
        end else if (rd && PADDR == `SAC_OFS_RES_HIGH) begin
            lock_reg <= 1'b0; // see RULE10
        end else if (rd && PADDR == `SAC_OFS_RES_LOW) begin
            lock_reg <= 1'b1; // see RULE8
        end
    end

    // Read data mux and error on unmapped address
    always_comb begin
        PRDATA = 32'h0000_0000;
        PSLVERR = 1'b0;
        case (PADDR)
            `SAC_OFS_INPUT_SEL: PRDATA = {24'h0, in_sel_reg};
            `SAC_OFS_CTRL_A: PRDATA = {24'h0, ctrl_a_reg};
            `SAC_OFS_CTRL_B: PRDATA = {29'h0, trig_sel_reg};
            `SAC_OFS_RES_LOW: PRDATA = {24'h0, res_low_reg};
            `SAC_OFS_RES_HIGH: PRDATA = {24'h0, res_high_reg};
            `SAC_OFS_POWER: PRDATA = {31'h0, power_gate_reg};
            default: PSLVERR = PSEL && PENABLE;
        endcase
    end

    // Completion sets done flag
    a_done_sets_flag: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        done |=> ctrl_a_reg[`SAC_DONE_BIT]) else $error("done flag not set"); // see RULE12
    // Locked result holds
    a_lock_holds_res: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        done && lock_reg |=> $stable(res_low_reg) && $stable(res_high_reg)) else $error("locked result changed"); // see RULE9
    // Low read locks
    a_low_read_locks: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rd && PADDR == `SAC_OFS_RES_LOW |=> lock_reg) else $error("lock not set"); // see RULE8
    // High read unlocks
    a_high_read_unlock: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rd && PADDR == `SAC_OFS_RES_HIGH |=> !lock_reg) else $error("lock not cleared"); // see RULE10
    // Start reads one while converting
    a_start_busy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state_reg == sac_pkg::ST_CONV && !done |=> ctrl_a_reg[`SAC_START_BIT]) else $error("start low in conversion"); // see RULE20
    // Disabled prescaler stays zero
    a_presc_reset: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !en |=> presc_reg == 7'h00) else $error("prescaler ran while disabled"); // see RULE22
    // Sync takes three cycles
    sequence s_sync3;
        state_reg == sac_pkg::ST_SYNC [*3];
    endsequence
    a_sync_three: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !en)
        state_reg == sac_pkg::ST_IDLE && trig_edge |=> s_sync3 ##1 state_reg == sac_pkg::ST_CONV)
        else $error("sync length wrong"); // see RULE24
    // Selection frozen during conversion
    a_mux_frozen: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state_reg == sac_pkg::ST_CONV |=> $stable(mux_act_reg)) else $error("selection changed mid conversion"); // see RULE14

    // Sequencing checks
    // These watch the control flow around completion and triggering.
    // A dropped enable resets the sequencer, so several checks are
    // disabled while the converter is off to avoid false reports.

    // Single mode completion drops the start bit
    a_single_clr_start: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        done && !(ctrl_a_reg[`SAC_AUTO_BIT] && trig_sel_reg == `SAC_TS_DONE) |=> !ctrl_a_reg[`SAC_START_BIT])
        else $error("start not cleared at completion"); // see RULE23
    // Free running restarts a conversion at once
    a_free_restart: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !en)
        done && ctrl_a_reg[`SAC_AUTO_BIT] && trig_sel_reg == `SAC_TS_DONE |=> state_reg == sac_pkg::ST_CONV && cyc_reg == 5'd0)
        else $error("free running did not restart"); // see RULE19
    // Trigger edge resets prescaler and enters sync
    a_edge_starts: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !en)
        state_reg == sac_pkg::ST_IDLE && trig_edge |=> state_reg == sac_pkg::ST_SYNC && presc_reg == 7'h00)
        else $error("trigger edge did not start"); // see RULE16
    // Disabled converter sits idle with start low
    a_off_idle: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !en |=> state_reg == sac_pkg::ST_IDLE && !ctrl_a_reg[`SAC_START_BIT])
        else $error("disabled converter busy"); // see RULE6
    // Sampling happens before any bit trial
    a_hold_window: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        SAMPLE_HOLD |-> state_reg == sac_pkg::ST_CONV && bit_reg == 4'd9 && sar_reg == 10'h200)
        else $error("sampling overlaps bit trials"); // see RULE25
    // Right alignment leaves the upper high bits clear
    a_right_align: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        done && !lock_reg && !cur_left |=> res_high_reg[7:2] == 6'h00)
        else $error("right aligned high byte wrong"); // see RULE7
    // Completion lands on the last converter clock
    a_conv_length: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        done |-> cyc_reg == (first_reg ? 5'd24 : 5'd12))
        else $error("conversion length wrong"); // see RULE21
endmodule
`default_nettype wire

// [logic/sac_params.svh]
// Constants for the converter control block
// Contract
// RULE1: Ten-bit code, zero is ground.
// RULE2: Reference bits pick supply, 1.1V or pin.
// RULE3: Channel bits route pin, ground or bandgap.
// RULE4: Eight single-ended channels from one port.
// RULE5: Selections apply only once enabled.
// RULE6: Power gate set makes converter unusable.
// RULE7: Right-aligned result, left when selected.
// RULE8: Low byte read blocks result updates.
// RULE9: Blocked completion discards the new result.
// RULE10: High byte read re-enables updates.
// RULE11: Software reads low byte before high.
// RULE12: Done flag raised even when discarded.
// RULE13: Start bit begins conversion, clears when done.
// RULE14: Channel change mid-conversion waits until finished.
// RULE15: Auto trigger uses selected source.
// RULE16: Trigger rising edge resets prescaler, starts.
// RULE17: Edges during conversion ignored, levels too.
// RULE18: Trigger flag must clear before retriggering.
// RULE19: Done-flag source runs conversions back to back.
// RULE20: Software start works in auto mode too.
// RULE21: Thirteen cycles, twenty-five for the first.
// RULE22: Prescaler counts while enabled, else reset.
// RULE23: Completion writes result, sets flag, clears start.
// RULE24: Trigger sync adds three CPU cycles.
// RULE25: One result bit per converter clock.
// RULE26: Reset clears control bits and result.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
// Register byte addresses
`define SAC_OFS_INPUT_SEL 12'h000
`define SAC_OFS_CTRL_A 12'h004
`define SAC_OFS_CTRL_B 12'h008
`define SAC_OFS_RES_LOW 12'h00c
`define SAC_OFS_RES_HIGH 12'h010
`define SAC_OFS_POWER 12'h014
// Input select fields
`define SAC_MUX_LSB 0
`define SAC_LEFT_BIT 5
`define SAC_REF_LSB 6
// Control A fields
`define SAC_PS_LSB 0
`define SAC_DONE_BIT 4
`define SAC_AUTO_BIT 5
`define SAC_START_BIT 6
`define SAC_EN_BIT 7
// Control B trigger field
`define SAC_TS_LSB 0
// Timing in converter clocks, sync delay in core clocks
`define SAC_NORMAL_CYC 5'd13
`define SAC_FIRST_CYC 5'd25
`define SAC_SYNC_CYC 2'd3
// Trigger source code for the done flag
`define SAC_TS_DONE 3'h0
`endif

// [logic/sac_pkg.sv]
// Types for the converter control block
package sac_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_CONV} sac_state_e;
    typedef struct packed {
        logic [2:0] channel; // Pin channel of port
        logic use_gnd; // Ground selected
        logic use_bg; // Bandgap selected
        logic [1:0] ref_sel; // Reference choice
    } sac_mux_s;
endpackage

// [test/sac_analog_model.sv]
// Behavioural model of the analog inputs and comparator behind the converter
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model #(
    parameter logic [9:0] BANDGAP_LEVEL = 10'h168 // Bandgap input as a code
) (
    input wire logic clk,
    input wire logic ana_enable,
    input wire logic [3:0] mux_sel,
    input wire logic [9:0] dac_code,
    output logic cmp_out
);
    logic [9:0] level; // Routed input voltage expressed as a code
    logic flip = 1'b0; // Junk level while the analog side is down
    // Pins ramp with channel number, ground reads zero
    always_comb begin
        if (mux_sel < 4'h8) begin
            level = {mux_sel[2:0], 7'h25};
        end else if (mux_sel == 4'h9) begin
            level = BANDGAP_LEVEL;
        end else begin
            level = 10'h000;
        end
    end
    // Powered-down comparator gives no stable answer
    always_ff @(posedge clk) begin
        flip <= ~flip;
    end
    // Keep the trial bit while the input is at or above it
    assign cmp_out = ana_enable ? (level >= dac_code) : flip;
endmodule
`default_nettype wire

// [test/test_sac_adc_ctrl.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module test_sac_adc_ctrl;
    logic core_clk = 1'b0; // 50 MHz clock
    logic sys_rst = 1'b1; // Held high at start
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] trig_in = 8'h00; // Trigger source levels
    logic cmp_out;
    logic [9:0] dac_code;
    logic [3:0] ana_mux_sel;
    logic [1:0] ana_ref_sel;
    logic ana_enable;
    logic sample_hold;
    int fails = 0;
    int checked = 0;
    int cycles = 0; // Hang guard count
    logic [7:0] rd_val = 8'h00; // Last byte read
    logic err_seen = 1'b0; // Last error response
    always #10 core_clk = ~core_clk;
    sac_adc_ctrl i_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TRIG_IN(trig_in), .CMP_OUT(cmp_out), .DAC_CODE(dac_code),
        .ANA_MUX_SEL(ana_mux_sel), .ANA_REF_SEL(ana_ref_sel), .ANA_ENABLE(ana_enable),
        .SAMPLE_HOLD(sample_hold));
    sac_analog_model i_ana (.clk(core_clk), .ana_enable(ana_enable), .mux_sel(ana_mux_sel),
        .dac_code(dac_code), .cmp_out(cmp_out));
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Compare one byte
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd_val = prdata[7:0];
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll control A until one bit reaches a value
    task automatic wait_ctrl(input int b, input logic v);
        int n = 0;
        rd_val[b] = ~v;
        while (rd_val[b] !== v && n < 400) begin
            apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
            n++;
        end
    endtask
    // Expected code of an input channel
    function automatic logic [9:0] lvl(input logic [4:0] ch);
        if (ch == 5'h1f) begin
            return 10'h000;
        end
        if (ch == 5'h1e) begin
            return 10'h168;
        end
        return {ch[2:0], 7'h25};
    endfunction
    // Single conversion on a channel, clearing the done flag with the start
    task automatic conv(input logic [4:0] ch, input logic left);
        logic [9:0] c;
        c = lvl(ch);
        apb(1'b1, `SAC_OFS_INPUT_SEL, {2'b01, left, ch});
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hd0);
        wait_ctrl(6, 1'b0);
        check({7'h0, rd_val[4]}, 8'h01);
        check(dac_code[7:0], c[7:0]);
        check({6'h0, ana_ref_sel}, 8'h01);
    endtask
    // Read low then high result byte and compare
    task automatic chk_res(input logic [4:0] ch, input logic left);
        logic [9:0] c;
        c = lvl(ch);
        apb(1'b0, `SAC_OFS_RES_LOW, 8'h00);
        check(rd_val, left ? {c[1:0], 6'h00} : c[7:0]);
        apb(1'b0, `SAC_OFS_RES_HIGH, 8'h00);
        check(rd_val, left ? c[9:2] : {6'h00, c[9:8]});
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            $display("ERROR %0t timeout", $time);
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check(rd_val, 8'h00);
        apb(1'b0, `SAC_OFS_RES_LOW, 8'h00);
        check(rd_val, 8'h00);
        apb(1'b0, `SAC_OFS_RES_HIGH, 8'h00);
        check(rd_val, 8'h00);
        $display("test reset done");
        // Start while disabled is ignored; power gate holds analog side down
        apb(1'b1, `SAC_OFS_INPUT_SEL, 8'hc3);
        check({4'h0, ana_mux_sel}, 8'h00);
        check({6'h0, ana_ref_sel}, 8'h00);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'h40);
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check(rd_val, 8'h00);
        check({7'h0, ana_enable}, 8'h00);
        apb(1'b1, `SAC_OFS_POWER, 8'h01);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'h80);
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check({7'h0, ana_enable}, 8'h00);
        apb(1'b1, `SAC_OFS_POWER, 8'h00);
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check({7'h0, ana_enable}, 8'h01);
        check({4'h0, ana_mux_sel}, 8'h03);
        check({6'h0, ana_ref_sel}, 8'h03);
        $display("test enable done");
        // Every pin, alignment alternating with channel, then bandgap and ground
        for (int ch = 0; ch < 8; ch++) begin
            conv(ch[4:0], ch[0]);
            chk_res(ch[4:0], ch[0]);
        end
        conv(5'h1e, 1'b0);
        chk_res(5'h1e, 1'b0);
        conv(5'h1f, 1'b1);
        chk_res(5'h1f, 1'b1);
        $display("test single done");
        // Channel written mid-conversion applies only afterwards
        apb(1'b1, `SAC_OFS_INPUT_SEL, 8'h41);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hd0);
        apb(1'b1, `SAC_OFS_INPUT_SEL, 8'h45);
        wait_ctrl(6, 1'b0);
        chk_res(5'h01, 1'b0);
        check({4'h0, ana_mux_sel}, 8'h05);
        $display("test channel change done");
        // Low read locks results; blocked completion still flags done
        conv(5'h02, 1'b0);
        apb(1'b0, `SAC_OFS_RES_LOW, 8'h00);
        conv(5'h06, 1'b0);
        chk_res(5'h02, 1'b0);
        conv(5'h06, 1'b0);
        chk_res(5'h06, 1'b0);
        $display("test lock done");
        // Trigger edge starts one conversion, held level starts no more
        apb(1'b1, `SAC_OFS_CTRL_B, 8'h01);
        apb(1'b1, `SAC_OFS_INPUT_SEL, 8'h43);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hb0);
        trig_in <= 8'h02;
        repeat (4) @(posedge core_clk);
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check({7'h0, rd_val[6]}, 8'h01);
        wait_ctrl(4, 1'b1);
        chk_res(5'h03, 1'b0);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hb0);
        repeat (100) @(posedge core_clk);
        apb(1'b0, `SAC_OFS_CTRL_A, 8'h00);
        check({7'h0, rd_val[4]}, 8'h00);
        trig_in <= 8'h00;
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hf0);
        wait_ctrl(6, 1'b0);
        check({7'h0, rd_val[4]}, 8'h01);
        $display("test trigger done");
        // Done flag as source runs conversions back to back
        apb(1'b1, `SAC_OFS_CTRL_B, 8'h00);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hf0);
        wait_ctrl(4, 1'b1);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'hb0);
        wait_ctrl(4, 1'b1);
        check({7'h0, rd_val[4]}, 8'h01);
        apb(1'b1, `SAC_OFS_CTRL_A, 8'h90);
        $display("test free running done");
        // Unmapped address answers with an error and zero
        apb(1'b0, 12'h018, 8'h00);
        check({7'h0, err_seen}, 8'h01);
        check(rd_val, 8'h00);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
`default_nettype wire
